/* File: hdl/qrd_pkg.sv */
// constants for the queued read field decoder
`default_nettype none
package qrd_pkg;
  localparam int unsigned     CLK_MHZ      = 250;
  localparam int unsigned     FINE_US      = 10000;   // 10 ms
  localparam int unsigned     COARSE_US    = 500000;  // 0.5 s
  localparam int unsigned     TICK_CYCLES  = FINE_US * CLK_MHZ;
  localparam int unsigned     COARSE_TICKS = COARSE_US / FINE_US;
  localparam int unsigned     SLOTS        = 32;
  localparam int unsigned     TAG_W        = 5;
  localparam int unsigned     LIM_W        = 13;
  localparam logic [1:0]      PRIORITY_FIELD_NORMAL  = 2'h0;
  localparam logic [1:0]      PRIORITY_FIELD_ISO     = 2'h1;
  localparam logic [1:0]      PRIORITY_FIELD_HIGH    = 2'h2;
  localparam int unsigned     CODE_COARSE  = 7;
  localparam logic [11:0]     REG_CTRL     = 12'h000;
  localparam logic [11:0]     REG_ACTIVE   = 12'h004;
  localparam logic [11:0]     REG_EXPIRED  = 12'h008;
  localparam logic [11:0]     REG_HIGH     = 12'h00C;
  localparam int unsigned     CTRL_ABORT   = 0;
  localparam logic            CTRL_RESET   = 1'h0;
endpackage
`default_nettype wire

/* File: hdl/qrd_tick_gen.sv */
// 10 ms tick enable divider
`default_nettype none
module qrd_tick_gen #(
  parameter int unsigned TICK_CYCLES = qrd_pkg::TICK_CYCLES
) (
  input  wire logic core_clk_in,
  input  wire logic sys_rst_in,
  output logic      tick_out
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } qrd_tick_type;

  qrd_tick_type st_r;
  qrd_tick_type st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt == 32'(TICK_CYCLES - 1)) begin
      st_nxt.cnt  = 32'h0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_out = st_r.tick;
endmodule
`default_nettype wire

/* File: hdl/qrd_decoder.sv */
// queued read field decoder with per-tag deadline tracking
`default_nettype none
module qrd_decoder #(
  parameter int unsigned TICK_CYCLES = qrd_pkg::TICK_CYCLES
) (
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        cmd_valid_in,
  input  wire logic [4:0]  cmd_tag_in,
  input  wire logic [1:0]  priority_field_in,
  input  wire logic [7:0]  deadline_code_in,
  input  wire logic        force_media_access_in,
  input  wire logic        done_valid_in,
  input  wire logic [4:0]  done_tag_in,
  output logic             dec_valid_out,
  output logic [4:0]       dec_tag_out,
  output logic [1:0]       dec_rank_out,
  output logic [12:0]      dec_limit_out,
  output logic             dec_cache_ok_out,
  output logic [31:0]      active_mask_out,
  output logic [31:0]      high_mask_out,
  output logic [31:0]      expired_mask_out,
  output logic [31:0]      abort_req_out
);
  localparam int unsigned N = qrd_pkg::SLOTS;
  localparam int unsigned W = qrd_pkg::LIM_W;

  typedef struct packed {
    logic [N-1:0]        active;
    logic [N-1:0]        iso;
    logic [N-1:0]        high;
    logic [N-1:0]        expired;
    logic [N-1:0][W-1:0] elapsed;
    logic [N-1:0][W-1:0] limit;
    logic                abort_en;
    logic [N-1:0]        abort_req;
    logic                dec_valid;
    logic [4:0]          dec_tag;
    logic [1:0]          dec_rank;
    logic [W-1:0]        dec_limit;
    logic                dec_cache_ok;
    logic [31:0]         prdata;
  } qrd_state_type;

  qrd_state_type st_r;
  qrd_state_type st_nxt;
  logic          tick;

  // fine units give code+1 ticks, coarse units scale by the coarse ratio
  function automatic logic [W-1:0] limit_ticks(input logic [7:0] code);
    logic [W-1:0] base;
    base = W'(code[6:0]) + W'(1);
    if (code[qrd_pkg::CODE_COARSE]) begin
      limit_ticks = W'(base * W'(qrd_pkg::COARSE_TICKS));
    end else begin
      limit_ticks = base;
    end
  endfunction

  qrd_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .tick_out    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic setup;
  assign setup = psel_in && !penable_in;

  always_comb begin
    st_nxt           = st_r;
    st_nxt.dec_valid = 1'b0;
    // apb: write takes effect in the access phase, read data latched in setup
    if (psel_in && penable_in && pwrite_in && paddr_in == qrd_pkg::REG_CTRL) begin
      st_nxt.abort_en = pwdata_in[qrd_pkg::CTRL_ABORT];
    end
    if (setup) begin
      if (paddr_in == qrd_pkg::REG_CTRL) begin
        st_nxt.prdata = {31'h0, st_r.abort_en};
      end else if (paddr_in == qrd_pkg::REG_ACTIVE) begin
        st_nxt.prdata = st_r.active;
      end else if (paddr_in == qrd_pkg::REG_EXPIRED) begin
        st_nxt.prdata = st_r.expired;
      end else if (paddr_in == qrd_pkg::REG_HIGH) begin
        st_nxt.prdata = st_r.high;
      end else begin
        st_nxt.prdata = 32'h0;
      end
    end
    // deadline ageing; expired commands stay active, never dropped
    for (int i = 0; i < N; i++) begin
      if (tick && st_r.active[i] && st_r.iso[i] && !st_r.expired[i]) begin
        st_nxt.elapsed[i] = st_r.elapsed[i] + W'(1);
        if (st_r.elapsed[i] + W'(1) >= st_r.limit[i]) begin
          st_nxt.expired[i] = 1'b1;
        end
      end
    end
    // completion frees the slot; a same-cycle accept below wins
    if (done_valid_in) begin
      st_nxt.active[done_tag_in]  = 1'b0;
      st_nxt.expired[done_tag_in] = 1'b0;
      st_nxt.iso[done_tag_in]     = 1'b0;
      st_nxt.high[done_tag_in]    = 1'b0;
    end
    // tags are trusted distinct; a reused tag simply restarts its slot
    if (cmd_valid_in) begin
      st_nxt.active[cmd_tag_in]  = 1'b1;
      st_nxt.expired[cmd_tag_in] = 1'b0;
      st_nxt.elapsed[cmd_tag_in] = '0;
      st_nxt.iso[cmd_tag_in]     = (priority_field_in == qrd_pkg::PRIORITY_FIELD_ISO);
      st_nxt.high[cmd_tag_in]    = (priority_field_in == qrd_pkg::PRIORITY_FIELD_HIGH);
      st_nxt.limit[cmd_tag_in]   = limit_ticks(deadline_code_in);
      st_nxt.dec_valid           = 1'b1;
      st_nxt.dec_tag             = cmd_tag_in;
      st_nxt.dec_cache_ok        = !force_media_access_in;
      // reserved 11b is served as normal
      if (priority_field_in == qrd_pkg::PRIORITY_FIELD_HIGH) begin
        st_nxt.dec_rank = qrd_pkg::PRIORITY_FIELD_HIGH;
      end else if (priority_field_in == qrd_pkg::PRIORITY_FIELD_ISO) begin
        st_nxt.dec_rank = qrd_pkg::PRIORITY_FIELD_ISO;
      end else begin
        st_nxt.dec_rank = qrd_pkg::PRIORITY_FIELD_NORMAL;
      end
      if (priority_field_in == qrd_pkg::PRIORITY_FIELD_ISO) begin
        st_nxt.dec_limit = limit_ticks(deadline_code_in);
      end else begin
        st_nxt.dec_limit = '0;
      end
    end
    st_nxt.abort_req = st_nxt.expired & {N{st_nxt.abort_en}};
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r          <= '0;
      st_r.abort_en <= qrd_pkg::CTRL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic mapped;
  assign mapped = (paddr_in == qrd_pkg::REG_CTRL) || (paddr_in == qrd_pkg::REG_ACTIVE)
               || (paddr_in == qrd_pkg::REG_EXPIRED) || (paddr_in == qrd_pkg::REG_HIGH);
  assign pready_out       = 1'b1;
  assign pslverr_out      = psel_in && penable_in && !mapped;
  assign prdata_out       = st_r.prdata;
  assign dec_valid_out    = st_r.dec_valid;
  assign dec_tag_out      = st_r.dec_tag;
  assign dec_rank_out     = st_r.dec_rank;
  assign dec_limit_out    = st_r.dec_limit;
  assign dec_cache_ok_out = st_r.dec_cache_ok;
  assign active_mask_out  = st_r.active;
  assign high_mask_out    = st_r.high;
  assign expired_mask_out = st_r.expired;
  assign abort_req_out    = st_r.abort_req;

  ////////////////////////////////////////////////////////////////////////////
  property p_iso_only;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      cmd_valid_in && priority_field_in != qrd_pkg::PRIORITY_FIELD_ISO |=> dec_limit_out == 13'h0;
  endproperty
  a_iso_only: assert property (p_iso_only) else $error("limit set for non-iso");

  property p_fine;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      cmd_valid_in && priority_field_in == qrd_pkg::PRIORITY_FIELD_ISO && !deadline_code_in[7]
      |=> dec_limit_out == 13'($past(deadline_code_in[6:0])) + 13'h1;
  endproperty
  a_fine: assert property (p_fine) else $error("fine limit wrong");

  property p_coarse;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      cmd_valid_in && priority_field_in == qrd_pkg::PRIORITY_FIELD_ISO && deadline_code_in[7]
      |=> dec_limit_out == (13'($past(deadline_code_in[6:0])) + 13'h1)
                           * 13'(qrd_pkg::COARSE_TICKS);
  endproperty
  a_coarse: assert property (p_coarse) else $error("coarse limit wrong");

  property p_force_media;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      cmd_valid_in && force_media_access_in |=> dec_valid_out && !dec_cache_ok_out;
  endproperty
  a_force_media: assert property (p_force_media) else $error("cache allowed");

  property p_cache_ok;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      cmd_valid_in && !force_media_access_in |=> dec_cache_ok_out;
  endproperty
  a_cache_ok: assert property (p_cache_ok) else $error("cache refused");

  property p_keep;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      (expired_mask_out & ~active_mask_out) == 32'h0;
  endproperty
  a_keep: assert property (p_keep) else $error("expired slot dropped");

  property p_abort;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      abort_req_out == (st_r.abort_en ? expired_mask_out : 32'h0);
  endproperty
  a_abort: assert property (p_abort) else $error("abort request wrong");

  property p_high;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      cmd_valid_in && priority_field_in == qrd_pkg::PRIORITY_FIELD_HIGH
      |=> dec_rank_out == qrd_pkg::PRIORITY_FIELD_HIGH && high_mask_out[$past(cmd_tag_in)];
  endproperty
  a_high: assert property (p_high) else $error("high priority lost");

  property p_start;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      cmd_valid_in |=> st_r.elapsed[$past(cmd_tag_in)] == 13'h0
                       && active_mask_out[$past(cmd_tag_in)];
  endproperty
  a_start: assert property (p_start) else $error("deadline not restarted");

  c_expire: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
                            $rose(|expired_mask_out));
  c_abort:  cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
                            |abort_req_out);
  c_both:   cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
                            cmd_valid_in && done_valid_in && cmd_tag_in == done_tag_in);
endmodule
`default_nettype wire

/* File: tb/qrd_host_model.sv */
// host side model issuing queued reads and completions
`default_nettype none
module qrd_host_model (
  input  wire logic  core_clk_in,
  output logic       cmd_valid_out,
  output logic [4:0] cmd_tag_out,
  output logic [1:0] priority_field_out,
  output logic [7:0] deadline_code_out,
  output logic       force_media_access_out,
  output logic       done_valid_out,
  output logic [4:0] done_tag_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] busy_r;
  initial begin
    busy_r = 32'h0;
    cmd_valid_out = 1'b0;
    cmd_tag_out = 5'h00;
    priority_field_out = 2'h0;
    deadline_code_out = 8'h00;
    force_media_access_out = 1'b0;
    done_valid_out = 1'b0;
    done_tag_out = 5'h00;
  end
  // a tag still outstanding is never sent again
  task automatic issue(input logic [4:0] t, input logic [1:0] p, input logic [7:0] c,
                       input logic f);
    if (busy_r[t]) return;
    @(posedge core_clk_in);
    cmd_valid_out <= 1'b1;
    cmd_tag_out <= t;
    priority_field_out <= p;
    deadline_code_out <= c;
    force_media_access_out <= f;
    busy_r[t] = 1'b1;
    @(posedge core_clk_in);
    // fields are meaningless outside the pulse, so show garbage there
    cmd_valid_out <= 1'b0;
    cmd_tag_out <= ~t;
    priority_field_out <= ~p;
    deadline_code_out <= ~c;
    force_media_access_out <= ~f;
  endtask
  task automatic finish(input logic [4:0] t);
    @(posedge core_clk_in);
    done_valid_out <= 1'b1;
    done_tag_out <= t;
    busy_r[t] = 1'b0;
    @(posedge core_clk_in);
    done_valid_out <= 1'b0;
    done_tag_out <= ~t;
  endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the queued read field decoder
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;  // short tick keeps the coarse case at a few hundred cycles
  logic        clk = 1'b0, sys_rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, active, high, expired, abort, rd;
  logic        pready, pslverr, cmd_v, done_v, fma, dec_v, dec_ok, er, f;
  logic [4:0]  tag, done_tag, dec_tag, t;
  logic [1:0]  pf, dec_rank, p;
  logic [7:0]  code, c;
  logic [12:0] dec_lim;
  logic [31:0] exp_act = 32'h0, exp_high = 32'h0;
  logic [7:0]  edge_codes [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
  int          errors = 0, check_count = 0;
  always #2 clk = ~clk;
  qrd_decoder #(.TICK_CYCLES(TK)) u_dut (.core_clk_in(clk), .sys_rst_in(sys_rst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .cmd_valid_in(cmd_v), .cmd_tag_in(tag), .priority_field_in(pf), .deadline_code_in(code),
    .force_media_access_in(fma), .done_valid_in(done_v), .done_tag_in(done_tag),
    .dec_valid_out(dec_v), .dec_tag_out(dec_tag), .dec_rank_out(dec_rank),
    .dec_limit_out(dec_lim), .dec_cache_ok_out(dec_ok), .active_mask_out(active),
    .high_mask_out(high), .expired_mask_out(expired), .abort_req_out(abort));
  qrd_host_model u_host (.core_clk_in(clk), .cmd_valid_out(cmd_v), .cmd_tag_out(tag),
    .priority_field_out(pf), .deadline_code_out(code), .force_media_access_out(fma),
    .done_valid_out(done_v), .done_tag_out(done_tag));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // limit in 10 ms ticks, zero unless isochronous
  function automatic int lim(input logic [1:0] pr, input logic [7:0] cd);
    if (pr != 2'h1) return 0;
    return (int'(cd[6:0]) + 1) * (cd[7] ? 50 : 1);
  endfunction
  task automatic wait_bit(input int b, input int n);
    for (int k = 0; k < n && expired[b] !== 1'b1; k++) @(posedge clk);
    #1;
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    errors++;
    final_report();
  end
  initial begin
    void'($urandom(33107));
    repeat (3) @(posedge clk);
    sys_rst_in <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      apb(1'b0, 12'(4 * a), 32'h0);
      chk(rd === 32'h0 && er === 1'b0 && pready === 1'b1, "reset value");
    end
    // every priority code, then boundary deadline codes
    for (int i = 0; i < 8; i++) begin
      t = 5'(i + 8);
      p = (i < 4) ? 2'(i) : 2'h1;
      c = (i < 4) ? 8'($urandom) : edge_codes[i - 4];
      // keep the drawn bit: the model shows its inverse once the pulse is over
      f = 1'($urandom);
      u_host.issue(t, p, c, f);
      #1;
      chk(dec_v === 1'b1 && dec_tag === t, "decode pulse");
      chk(dec_rank === ((p == 2'h3) ? 2'h0 : p), "rank");
      chk(dec_lim === 13'(lim(p, c)), "limit");
      chk(dec_ok === ~f, "cache");
      exp_act[t] = 1'b1;
      if (p == 2'h2) exp_high[t] = 1'b1;
      chk(active === exp_act && high === exp_high, "masks");
    end
    for (int i = 8; i < 16; i++) u_host.finish(5'(i));
    @(posedge clk);
    #1;
    chk(active === 32'h0 && high === 32'h0, "done clears");
    // fine and coarse deadlines side by side
    u_host.issue(5'h03, 2'h1, 8'h02, 1'b0);
    u_host.issue(5'h04, 2'h1, 8'h80, 1'b1);
    repeat (TK) @(posedge clk);
    #1;
    chk(expired === 32'h0, "early expiry");
    wait_bit(3, 4 * TK);
    chk(expired === 32'h8 && active === 32'h18, "fine expiry");
    chk(abort === 32'h0, "no abort by default");
    repeat (150) @(posedge clk);
    #1;
    chk(expired[4] === 1'b0, "coarse early");
    apb(1'b1, 12'h000, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk(abort === 32'h8, "abort armed");
    wait_bit(4, 80);
    #4;
    chk(abort === 32'h18 && active === 32'h18, "coarse expiry");
    apb(1'b0, 12'h008, 32'h0);
    chk(rd === 32'h18, "expired read");
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd === 32'h18 && er === 1'b0, "read only");
    apb(1'b0, 12'h010, 32'h0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped");
    u_host.finish(5'h03);
    u_host.finish(5'h04);
    @(posedge clk);
    #2;
    chk(active === 32'h0 && expired === 32'h0 && abort === 32'h0, "cleanup");
    final_report();
  end
endmodule
`default_nettype wire
